// [design/orsy_ahb_regs.sv]
// ahb-lite slave holding the controller's own registers
`timescale 1ns/1ns
module orsy_ahb_regs
  import orsy_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // register contents
  input wire logic busy,
  input wire logic [31:0] status,
  output logic start_p,
  output logic stop_p,
  output logic acc_en,
  output logic gyr_en,
  output logic pol,
  output logic [7:0] samples,
  output logic [3:0] rate,
  output logic [31:0] period,
  output logic [31:0] pulse
);
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic wr;
  logic addr_ok;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // only whole words inside the low window are decoded
  assign addr_ok = hsel && htrans[1] && hready && hsize == 3'h2 &&
                   haddr[31:8] == 24'h0;
  assign wr = wr_pend_q;

  // address phase capture for writes
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h0;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end

  // config writes are refused while a sequence runs, keeping it coherent
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_en <= 1'b1;
      gyr_en <= 1'b1;
      pol <= 1'b1;
      samples <= SAMPLES_RST;
      rate <= RATE_RST;
      period <= PERIOD_RST;
      pulse <= PULSE_RST;
    end else if (wr && !busy) begin
      if (wr_addr_q == REG_CTRL) begin
        acc_en <= hwdata[CTRL_ACC_EN];
        gyr_en <= hwdata[CTRL_GYR_EN];
        pol <= hwdata[CTRL_POL];
      end else if (wr_addr_q == REG_SAMPLES) begin
        samples <= hwdata[7:0];
      end else if (wr_addr_q == REG_RATE) begin
        rate <= hwdata[3:0];
      end else if (wr_addr_q == REG_PERIOD) begin
        period <= hwdata;
      end else if (wr_addr_q == REG_PULSE) begin
        pulse <= hwdata;
      end
    end
  end

  // self-clearing command bits
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      start_p <= 1'b0;
      stop_p <= 1'b0;
    end else begin
      start_p <= wr && wr_addr_q == REG_CTRL && hwdata[CTRL_START];
      stop_p <= wr && wr_addr_q == REG_CTRL && hwdata[CTRL_STOP];
    end
  end

  // read data latched in the address phase; unmapped word offsets in the low window give zero
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= 32'h0;
    end else if (addr_ok && !hwrite) begin
      if (haddr[7:0] == REG_CTRL) begin
        hrdata <= 32'({pol, gyr_en, acc_en, 2'b00});
      end else if (haddr[7:0] == REG_SAMPLES) begin
        hrdata <= 32'(samples);
      end else if (haddr[7:0] == REG_RATE) begin
        hrdata <= 32'(rate);
      end else if (haddr[7:0] == REG_PERIOD) begin
        hrdata <= period;
      end else if (haddr[7:0] == REG_PULSE) begin
        hrdata <= pulse;
      end else if (haddr[7:0] == REG_STATUS) begin
        hrdata <= status;
      end else begin
        hrdata <= 32'h0;
      end
    end
  end
endmodule : orsy_ahb_regs

// [design/orsy_ref_gen.sv]
// reference pulse train generator driving the device's reference pin
`timescale 1ns/1ns
module orsy_ref_gen
  import orsy_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // control
  input wire logic run,
  input wire logic pol,
  input wire logic [31:0] period,
  input wire logic [31:0] pulse,
  // pin and event
  output logic ref_pin,
  output logic edge_p
);
  logic [31:0] cnt_q;
  logic act_q;
  logic [31:0] width_q;

  // period counter; restarts from zero so the first edge comes at once
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 32'h0;
    end else if (!run || cnt_q >= period - 32'h1) begin
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  // active phase at the head of each period
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      act_q <= 1'b0;
    end else begin
      act_q <= run && (cnt_q < pulse);
    end
  end

  // idle level is the inactive one, so stopping never fakes an edge
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_pin <= 1'b1;
      edge_p <= 1'b0;
    end else begin
      ref_pin <= pol ? (run && cnt_q < pulse) : !(run && cnt_q < pulse);
      edge_p <= run && (cnt_q < pulse) && !act_q;
    end
  end

  // helper: width of the current active phase
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      width_q <= 32'h0;
    end else begin
      width_q <= act_q ? width_q + 32'h1 : 32'h0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_pulse_min_width: assert property (
    $fell(act_q) && run |-> width_q >= 32'(REF_PULSE_MIN_CYC))
    else $error("reference pulse shorter than minimum");
  a_pin_polarity: assert property (
    act_q |-> ref_pin == pol)
    else $error("reference pin level does not follow polarity");
endmodule : orsy_ref_gen

// [design/orsy_sync_ctrl.sv]
// host controller bringing a sensor into reference-synchronized mode
//
// Implementation choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ns
module orsy_sync_ctrl
  import orsy_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // device register write port, towards the serial engine
  output logic dev_wr_valid,
  output logic [7:0] dev_wr_addr,
  output logic [7:0] dev_wr_data,
  input wire logic dev_wr_ready,
  // reference pulse train into the device
  output logic reference_input_pin
);
  orsy_state_t state_q, state_d;
  logic start_p, stop_p, acc_en, gyr_en, pol;
  logic [7:0] samples;
  logic [3:0] rate;
  logic [31:0] period, pulse, status;
  logic ref_run_q, edge_p, err_q, cfg_ok, wr_done;
  logic [1:0] lock_cnt_q;
  logic [16:0] wr_word;
  logic [7:0] rate_word;
  logic [47:0] nom, span, min_per, per100, lo_lim, hi_lim;
  logic [8:0] two_n, min_smp;

  assign status = 32'({err_q, state_q == ST_RUN, state_q != ST_IDLE,
                       4'(state_q)});

  orsy_ahb_regs u_regs (
    .core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .busy(state_q != ST_IDLE), .status(status),
    .start_p(start_p), .stop_p(stop_p), .acc_en(acc_en),
    .gyr_en(gyr_en), .pol(pol), .samples(samples), .rate(rate),
    .period(period), .pulse(pulse)
  );

  orsy_ref_gen u_ref (
    .core_clk(core_clk), .rst_b(rst_b), .run(ref_run_q), .pol(pol),
    .period(period), .pulse(pulse), .ref_pin(reference_input_pin),
    .edge_p(edge_p)
  );

  // limits derived from the rate code
  always_comb begin
    two_n = {samples, 1'b0};
    nom = 48'(NOM_BASE_CYC) >> (rate - RATE_MIN);
    if (rate <= RATE_FLOOR) begin
      min_smp = MIN_SAMPLES;
      min_per = nom * 48'(MIN_PERIOD_MULT);
    end else begin
      min_smp = MIN_SAMPLES << (rate - RATE_FLOOR);
      min_per = 48'(PERIOD_FLOOR_CYC);
    end
    span = nom * 48'(two_n);
    per100 = 48'(period) * 48'd100;
    lo_lim = span * 48'(DEV_LO_PCT);
    hi_lim = span * 48'(DEV_HI_PCT);
  end

  // configuration check before anything reaches the device
  always_comb begin
    cfg_ok = (acc_en || gyr_en) &&
             rate >= RATE_MIN && rate <= RATE_MAX &&
             samples >= TRIG_N_MIN &&
             two_n >= min_smp &&
             48'(period) >= min_per &&
             per100 >= lo_lim && per100 <= hi_lim &&
             pulse >= 32'(REF_PULSE_MIN_CYC) && pulse < period;
  end

  // a disabled sensor stays synced but powered down (rate code 0000)
  always_comb begin
    rate_word = {1'b0, OPMODE_SYNC, rate};
  end

  // device write issued in each sequencer state except idle, start-ref, locking and run; msb marks a write
  function automatic logic [16:0] word_of(orsy_state_t s);
    logic [16:0] w;
    w = 17'h0;
    case (s)
      ST_ACC_PD: w = {1'b1, DEV_ACCEL_CTRL, DEV_POWER_DOWN};
      ST_GYR_PD: w = {1'b1, DEV_GYRO_CTRL, DEV_POWER_DOWN};
      ST_TRIG: w = {1'b1, DEV_SYNC_CFG, samples};
      ST_ACC_SYNC: w = {1'b1, DEV_ACCEL_CTRL, DEV_SYNC_PD};
      ST_GYR_SYNC: w = {1'b1, DEV_GYRO_CTRL, DEV_SYNC_PD};
      ST_PIN: w = {1'b1, DEV_PIN_CTRL, 7'h0, pol};
      ST_ACC_RATE: w = {1'b1, DEV_ACCEL_CTRL,
                        acc_en ? rate_word : DEV_SYNC_PD};
      ST_GYR_RATE: w = {1'b1, DEV_GYRO_CTRL,
                        gyr_en ? rate_word : DEV_SYNC_PD};
      ST_ACC_OFF: w = {1'b1, DEV_ACCEL_CTRL, DEV_POWER_DOWN};
      ST_GYR_OFF: w = {1'b1, DEV_GYRO_CTRL, DEV_POWER_DOWN};
      default: w = 17'h0;
    endcase
    return w;
  endfunction : word_of

  assign wr_done = dev_wr_valid && dev_wr_ready;

  // sequencer: power down, count, mode, polarity, pulses, rates
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (start_p && cfg_ok) state_d = ST_ACC_PD;
      ST_ACC_PD: if (wr_done) state_d = ST_GYR_PD;
      ST_GYR_PD: if (wr_done) state_d = ST_TRIG;
      ST_TRIG: if (wr_done) state_d = ST_ACC_SYNC;
      ST_ACC_SYNC: if (wr_done) state_d = ST_GYR_SYNC;
      ST_GYR_SYNC: if (wr_done) state_d = ST_PIN;
      ST_PIN: if (wr_done) state_d = ST_START_REF;
      ST_START_REF: state_d = ST_ACC_RATE;
      ST_ACC_RATE: if (wr_done) state_d = ST_GYR_RATE;
      ST_GYR_RATE: if (wr_done) state_d = ST_LOCKING;
      ST_LOCKING: begin
        if (stop_p) begin
          state_d = ST_ACC_OFF;
        end else if (edge_p && lock_cnt_q == LOCK_LAST) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: if (stop_p) state_d = ST_ACC_OFF;
      ST_ACC_OFF: if (wr_done) state_d = ST_GYR_OFF;
      ST_GYR_OFF: if (wr_done) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // next device word; a process so the function's reads all count
  always_comb begin
    wr_word = word_of(state_d);
  end

  // write port loaded from the next state, so data sit in flops
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dev_wr_valid <= 1'b0;
      dev_wr_addr <= 8'h0;
      dev_wr_data <= 8'h0;
    end else begin
      dev_wr_valid <= wr_word[16];
      dev_wr_addr <= wr_word[15:8];
      dev_wr_data <= wr_word[7:0];
    end
  end

  // pulses run from before the rate writes until both sensors are off
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_run_q <= 1'b0;
    end else if (state_q == ST_START_REF) begin
      ref_run_q <= 1'b1;
    end else if (state_q == ST_IDLE) begin
      ref_run_q <= 1'b0;
    end
  end

  // active edges counted only in the locking state, after the rate writes are done
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_cnt_q <= 2'h0;
    end else if (state_q != ST_LOCKING) begin
      lock_cnt_q <= 2'h0;
    end else if (edge_p) begin
      lock_cnt_q <= lock_cnt_q + 2'h1;
    end
  end

  // error flag: set by a refused start, cleared by an accepted one
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      err_q <= 1'b0;
    end else if (state_q == ST_IDLE && start_p) begin
      err_q <= !cfg_ok;
    end
  end

  // no register of the charge-variation or stabilization path is touched

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_start_powers_down: assert property (
    state_q == ST_IDLE && start_p && cfg_ok |=> dev_wr_valid &&
    dev_wr_addr == DEV_ACCEL_CTRL && dev_wr_data == DEV_POWER_DOWN)
    else $error("sequence did not open with accel power-down");
  a_bad_start_refused: assert property (
    state_q == ST_IDLE && start_p && !cfg_ok |=> state_q == ST_IDLE && err_q)
    else $error("invalid configuration was not refused");
  a_sync_pd_value: assert property (
    state_q == ST_ACC_SYNC |-> dev_wr_data == 8'h30)
    else $error("sync entry value wrong");
  a_rate_code_legal: assert property (
    state_q == ST_GYR_RATE && gyr_en |-> dev_wr_data[3:0] >= RATE_MIN &&
    dev_wr_data[3:0] <= RATE_MAX)
    else $error("illegal rate code programmed");
  a_rates_common: assert property (
    state_q == ST_GYR_RATE && acc_en && gyr_en && wr_done |->
    dev_wr_data == $past(dev_wr_data, 1) || $past(state_q) == ST_GYR_RATE)
    else $error("accel and gyro rate differ");
  a_write_held: assert property (
    dev_wr_valid && !dev_wr_ready |=> dev_wr_valid &&
    $stable(dev_wr_addr) && $stable(dev_wr_data))
    else $error("device write dropped before acceptance");
  a_ref_before_rates: assert property (
    state_q == ST_ACC_RATE |-> ref_run_q)
    else $error("rates programmed before reference started");
  a_lock_three_edges: assert property (
    state_q == ST_LOCKING && edge_p && lock_cnt_q == LOCK_LAST && !stop_p
    |=> state_q == ST_RUN)
    else $error("lock not declared on third edge");
  a_samples_field: assert property (
    state_q == ST_TRIG |-> dev_wr_data >= TRIG_N_MIN)
    else $error("samples field below minimum");
  a_stop_powers_down: assert property (
    state_q == ST_RUN && stop_p |=> ##1 dev_wr_valid &&
    dev_wr_data == DEV_POWER_DOWN)
    else $error("stop did not power down sensors");

  c_reach_run: cover property (state_q == ST_LOCKING ##1 state_q == ST_RUN);
  c_refused: cover property (state_q == ST_IDLE && start_p && !cfg_ok);
  c_stop_done: cover property (state_q == ST_GYR_OFF ##1 state_q == ST_IDLE);
  c_stalled_write: cover property (dev_wr_valid && !dev_wr_ready);
endmodule : orsy_sync_ctrl

// [include/orsy_pkg.sv]
// constants, types and register map for the reference-sync controller
package orsy_pkg;
  // clock and timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int CLK_HZ = 250_000_000;
  localparam int REF_PULSE_MIN_NS = 5000;
  localparam int REF_PULSE_MIN_CYC =
    (REF_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PERIOD_FLOOR_MS = 40;
  localparam int PERIOD_FLOOR_CYC = PERIOD_FLOOR_MS * (CLK_HZ / 1000);
  // nominal sample period of code 0011 (12.5 Hz) in cycles
  localparam int NOM_BASE_CYC = (CLK_HZ * 2) / 25;
  localparam int LOCK_PERIODS = 3;
  localparam logic [1:0] LOCK_LAST = 2'(LOCK_PERIODS - 1);
  localparam int DEV_LO_PCT = 67;
  localparam int DEV_HI_PCT = 133;
  // rate codes and sample limits
  localparam logic [3:0] RATE_MIN = 4'h3;
  localparam logic [3:0] RATE_MAX = 4'hb;
  localparam logic [3:0] RATE_FLOOR = 4'h7;
  localparam logic [8:0] MIN_SAMPLES = 9'h008;
  localparam int MIN_PERIOD_MULT = 8;
  localparam logic [7:0] TRIG_N_MIN = 8'h04;
  // device register addresses and values (addresses arbitrary)
  localparam logic [7:0] DEV_ACCEL_CTRL = 8'h01;
  localparam logic [7:0] DEV_GYRO_CTRL = 8'h02;
  localparam logic [7:0] DEV_PIN_CTRL = 8'h03;
  localparam logic [7:0] DEV_SYNC_CFG = 8'h04;
  localparam logic [2:0] OPMODE_SYNC = 3'h3;
  localparam logic [7:0] DEV_POWER_DOWN = 8'h00;
  localparam logic [7:0] DEV_SYNC_PD = {1'b0, OPMODE_SYNC, 4'h0};
  // own register map, byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SAMPLES = 8'h04;
  localparam logic [7:0] REG_RATE = 8'h08;
  localparam logic [7:0] REG_PERIOD = 8'h0c;
  localparam logic [7:0] REG_PULSE = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  // control and status fields
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_ACC_EN = 2;
  localparam int CTRL_GYR_EN = 3;
  localparam int CTRL_POL = 4;
  localparam int STAT_BUSY = 4;
  localparam int STAT_LOCK = 5;
  localparam int STAT_ERR = 6;
  // values after reset
  localparam logic [7:0] SAMPLES_RST = 8'h04;
  localparam logic [3:0] RATE_RST = 4'h6;
  localparam logic [31:0] PERIOD_RST = 32'h0131_2d00;
  localparam logic [31:0] PULSE_RST = 32'h0000_09c4;
  // sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_ACC_PD = 4'h1, ST_GYR_PD = 4'h2, ST_TRIG = 4'h3,
    ST_ACC_SYNC = 4'h4, ST_GYR_SYNC = 4'h5, ST_PIN = 4'h6,
    ST_START_REF = 4'h7, ST_ACC_RATE = 4'h8, ST_GYR_RATE = 4'h9,
    ST_LOCKING = 4'ha, ST_RUN = 4'hb, ST_ACC_OFF = 4'hc, ST_GYR_OFF = 4'hd
  } orsy_state_t;
endpackage : orsy_pkg

// [sim/odr_reference_sync_tb_top.sv]
// self-checking bench for the reference-sync controller
`timescale 1ns/1ns
module odr_reference_sync_tb_top;
  import orsy_pkg::*;
  logic core_clk, rst_b, hsel, hwrite, pol;
  logic [31:0] haddr, hwdata, rd, cw, pw;
  logic [1:0] htrans, en;
  logic [2:0] hsize;
  logic [7:0] bs[8];
  logic [3:0] br[8];
  logic [15:0] ew[10];
  wire hready, hresp, dev_wr_valid, dev_wr_ready, pin;
  wire [31:0] hrdata;
  wire [7:0] dev_wr_addr, dev_wr_data;
  int n_fail, tests_run, cyc, i;
  int seed = 32'h9e4785f5;

  orsy_sync_ctrl dut_u (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hrdata(hrdata),
    .hresp(hresp), .dev_wr_valid(dev_wr_valid), .dev_wr_addr(dev_wr_addr),
    .dev_wr_data(dev_wr_data), .dev_wr_ready(dev_wr_ready),
    .reference_input_pin(pin));
  orsy_dev_model model_u (.core_clk(core_clk), .rst_b(rst_b),
    .dev_wr_valid(dev_wr_valid), .dev_wr_addr(dev_wr_addr),
    .dev_wr_data(dev_wr_data), .dev_wr_ready(dev_wr_ready),
    .reference_input_pin(pin));

  task automatic stop_test();
    $display("checks=%0d failures=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // single word transfer; hangs are cut by the cycle ceiling
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge core_clk);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1);
    r = hrdata;
  endtask : ahb

  // start legality from field limits, rate table and deviation window
  function automatic logic bad(input logic [7:0] s, input logic [3:0] r,
                               input logic [31:0] p);
    logic [63:0] nom, mn;
    if (r < 4'h3 || r > 4'hb || s < 8'h04) return 1'b1;
    nom = 64'(NOM_BASE_CYC) >> (r - 4'h3);
    mn = (r <= 4'h7) ? 64'd8 : 64'd8 << (r - 4'h7);
    if ({s, 1'b0} < mn) return 1'b1;
    if (p < ((r <= 4'h7) ? nom * 8 : 64'd10_000_000)) return 1'b1;
    return 64'(p) * 100 < nom * 2 * s * 67 || 64'(p) * 100 > nom * 2 * s * 133;
  endfunction : bad

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // hang guard: whole run needs well under this many cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 30000) begin
      n_fail++;
      stop_test();
    end
  end

  initial begin
    rst_b = 1'b0;
    hsel = 1'b1;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    // reset values, unmapped place reads zero
    ahb(0, REG_CTRL, 0, rd); chk(rd, 32'h1c);
    ahb(0, REG_SAMPLES, 0, rd); chk(rd, 32'h04);
    ahb(0, REG_RATE, 0, rd); chk(rd, 32'h06);
    ahb(0, REG_PERIOD, 0, rd); chk(rd, 32'd20_000_000);
    ahb(0, REG_PULSE, 0, rd); chk(rd, 32'd2500);
    ahb(0, REG_STATUS, 0, rd); chk(rd, 32'h0);
    ahb(1, 8'h18, 32'hffff, rd);
    ahb(0, 8'h18, 0, rd); chk(rd, 32'h0);
    // refused starts: hand corners then random reserved rate codes
    bs = '{8'h03, 8'h04, 8'h04, 8'h3f, 8'h04, 8'h04, 8'h00, 8'h00};
    br = '{4'h6, 4'h2, 4'hc, 4'hb, 4'h7, 4'h0, 4'h0, 4'h0};
    for (i = 0; i < 8; i++) begin
      if (i > 5) begin
        bs[i] = 8'($random(seed));
        br[i] = 4'hc | 4'($random(seed));
      end
      ahb(1, REG_SAMPLES, {24'h0, bs[i]}, rd);
      ahb(1, REG_RATE, {28'h0, br[i]}, rd);
      ahb(1, REG_CTRL, 32'h1d, rd);
      repeat (4) @(posedge core_clk);
      ahb(0, REG_STATUS, 0, rd);
      chk(rd, {25'h0, bad(bs[i], br[i], 32'd20_000_000), 6'h0});
    end
    // good start at the top rate, random polarity and sensor set
    pol = 1'($random(seed));
    en = 2'({$random(seed)} % 3) + 2'h1;
    pw = 32'd1250 + ({$random(seed)} % 256);
    cw = {27'h0, pol, en, 2'b00};
    ahb(1, REG_SAMPLES, 32'h40, rd);
    ahb(1, REG_RATE, 32'hb, rd);
    ahb(1, REG_PERIOD, 32'd10_000_000, rd);
    ahb(1, REG_PULSE, pw, rd);
    ahb(1, REG_CTRL, cw, rd);
    repeat (2) @(negedge core_clk);
    chk({31'h0, pin}, {31'h0, !pol});
    ahb(1, REG_CTRL, cw | 32'h1, rd);
    ahb(1, REG_RATE, 32'h3, rd);
    ahb(0, REG_RATE, 0, rd); chk(rd, 32'hb);
    ahb(0, REG_CTRL, 0, rd); chk(rd, cw);
    i = 0;
    while (pin !== pol && i < 400) begin
      @(negedge core_clk);
      i++;
    end
    i = 0;
    while (pin === pol && i < 4000) begin
      @(negedge core_clk);
      i++;
    end
    chk(i, pw);
    ahb(0, REG_STATUS, 0, rd); chk(rd, 32'h1a);
    chk(model_u.edges_q, 1);
    chk({28'h0, model_u.acc_rate}, 32'hb);
    chk({23'h0, model_u.spp}, 32'd128);
    chk({31'h0, model_u.locked}, 32'h0);
    ahb(1, REG_CTRL, cw | 32'h2, rd);
    i = 0;
    do begin
      ahb(0, REG_STATUS, 0, rd);
      i++;
    end while (rd[3:0] !== 4'h0 && i < 50);
    chk(rd, 32'h0);
    repeat (2) @(negedge core_clk);
    chk({31'h0, pin}, {31'h0, !pol});
    ew = '{16'h0100, 16'h0200, 16'h0440, 16'h0130, 16'h0230,
           {8'h03, 7'h0, pol}, {8'h01, en[0] ? 8'h3b : 8'h30},
           {8'h02, en[1] ? 8'h3b : 8'h30}, 16'h0100, 16'h0200};
    chk(model_u.wq.size(), 10);
    for (i = 0; i < 10; i++) begin
      chk({16'h0, model_u.wq[i]}, {16'h0, ew[i]});
    end
    stop_test();
  end
endmodule : odr_reference_sync_tb_top

// [sim/orsy_dev_model.sv]
// device-side model: register writes, reference edge tracking, lock
`timescale 1ns/1ns
module orsy_dev_model
  import orsy_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // register write port
  input wire logic dev_wr_valid,
  input wire logic [7:0] dev_wr_addr,
  input wire logic [7:0] dev_wr_data,
  output logic dev_wr_ready,
  // reference pin
  input wire logic reference_input_pin
);
  logic [7:0] acc_q, gyr_q, pin_q, trig_q;
  logic ref_q;
  logic [15:0] wq[$];
  int edges_q;
  int mseed = 32'h9e4785f5;
  // gyro rate 0 means powered down whatever the mode bits
  wire gyr_pd = gyr_q[3:0] == 4'h0;
  wire [3:0] acc_rate = gyr_pd ? acc_q[3:0] : gyr_q[3:0];
  wire [8:0] spp = {trig_q, 1'b0};
  wire synced = acc_q[6:4] == OPMODE_SYNC || gyr_q[6:4] == OPMODE_SYNC;
  wire act = pin_q[0] ? (reference_input_pin & !ref_q)
                      : (!reference_input_pin & ref_q);
  wire locked = edges_q >= LOCK_PERIODS;
  // ready stalls at random so prompt and slow acceptance both occur
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dev_wr_ready <= 1'b0;
      acc_q <= 8'h00;
      gyr_q <= 8'h00;
      pin_q <= 8'h00;
      trig_q <= 8'h00;
    end else begin
      dev_wr_ready <= ($random(mseed) & 3) != 0;
      if (dev_wr_valid && dev_wr_ready) begin
        wq.push_back({dev_wr_addr, dev_wr_data});
        // control writes carry mode and rate only; full-scale stays apart
        case (dev_wr_addr)
          8'h01: acc_q <= dev_wr_data;
          8'h02: gyr_q <= dev_wr_data;
          8'h03: pin_q <= dev_wr_data;
          8'h04: trig_q <= dev_wr_data;
          default: ;
        endcase
      end
    end
  end
  // edges only count toward lock while synchronized
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_q <= 1'b0;
      edges_q <= 0;
    end else begin
      ref_q <= reference_input_pin;
      if (synced && act) edges_q <= edges_q + 1;
    end
  end
endmodule : orsy_dev_model
